// File: hw/io_cell_defines.vh
`ifndef IO_CELL_DEFINES_VH
`define IO_CELL_DEFINES_VH

// input path modes
`define IN_MODE_DIRECT   2'h0
`define IN_MODE_REG      2'h1
`define IN_MODE_DDR      2'h2

// output path modes
`define OUT_MODE_DIRECT  2'h0
`define OUT_MODE_REG     2'h1
`define OUT_MODE_DDR     2'h2

// output enable path modes
`define OE_MODE_DIRECT   1'h0
`define OE_MODE_REG      1'h1

// keeper selection
`define KEEP_NONE        1'h0
`define KEEP_PULLUP      1'h1

// wake-up values of cell flip-flops
`define CELL_FF_RESET    1'h0

// pad sampling depth for pin inputs
`define PAD_SYNC_DEPTH   3

`endif

// File: hw/io_pad_sync.v
`timescale 1ns/100ps
`include "io_cell_defines.vh"
// three-stage pad sampler; a change counts once stages two and three agree
module io_pad_sync
(
	// clock and reset
	input  wire i_clk,
	input  wire i_rst,
	// pad level
	input  wire i_pad,
	// filtered level
	output reg  o_level
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s1_reg  <= `CELL_FF_RESET;
			s2_reg  <= `CELL_FF_RESET;
			s3_reg  <= `CELL_FF_RESET;
			o_level <= `CELL_FF_RESET;
		end
		else
		begin
			s1_reg <= i_pad;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				o_level <= s3_reg;
		end
	end
endmodule

// File: hw/io_ce_flop.v
`timescale 1ns/100ps
`include "io_cell_defines.vh"
// edge-selectable flip-flop with clock enable and async wake-up value
module io_ce_flop
#(
	parameter NEG_EDGE = 0
)
(
	// clock and reset
	input  wire i_clk,
	input  wire i_rst,
	// data
	input  wire i_ce,
	input  wire i_d,
	output reg  o_q
);
	wire clk_int;

	assign clk_int = NEG_EDGE ? ~i_clk : i_clk;

	always @(posedge clk_int or posedge i_rst)
	begin
		if (i_rst)
			o_q <= `CELL_FF_RESET;
		else if (i_ce)
			o_q <= i_d;
	end
endmodule

// File: hw/io_cell.v
`timescale 1ns/100ps
`include "io_cell_defines.vh"
// Summary of operation
// R1 - optional registered input path by configuration
// R2 - ddr input: rise and fall samples
// R3 - optional registered output path by configuration
// R4 - ddr output: two bits muxed per clock
// R5 - input, output and tristate register blocks
// R6 - freeze latch holds unregistered input value
// R7 - one bank freeze control, per-cell opt-in
// R8 - registered inputs frozen by clock enable
// R9 - core freeze input drives the latch
// R10 - unconfigured pad floats with weak pull-up
// R11 - unused pad: input blocked, pull-up off
// R12 - pad floats until configuration completes
// R13 - cell logic idle until power-on reset releases; the pad sampler keeps sampling, reset by I_RST only
// R14 - per-pad keeper: pull-up or none
// R15 - global float control forces driver off
// R16 - global reset holds flops during configuration; the pad sampler flops are reset by I_RST only
// R17 - output enable drives pad, else floats
// R18 - clock enable gates the input, output and tristate registers
module io_cell
(
	// clocks and resets
	input  wire       I_MCLK,
	input  wire       I_RST,
	input  wire       I_POR,
	// configuration status
	input  wire       I_CFG_DONE,
	input  wire       I_GLOBAL_FLOAT_CONTROL,
	// static configuration
	input  wire       I_CELL_USED,
	input  wire [1:0] I_IN_MODE,
	input  wire [1:0] I_OUT_MODE,
	input  wire       I_OE_MODE,
	input  wire       I_FREEZE_EN,
	input  wire       I_KEEPER,
	// core side
	input  wire       I_INPUT_CLK,
	input  wire       I_OUTPUT_CLK,
	input  wire       I_CLOCK_ENABLE,
	input  wire       I_OUTPUT_ENABLE,
	input  wire       I_D_OUT_0,
	input  wire       I_D_OUT_1,
	input  wire       I_BANK_FREEZE,
	output reg        O_D_IN_0,
	output reg        O_D_IN_1,
	// pad side
	input  wire       I_PAD,
	output wire       O_PAD,
	output wire       O_PAD_OE,
	output wire       O_PAD_PULLUP
);
	//----------------------------------------
	// reset and configuration gating
	//----------------------------------------
	wire cell_rst;
	wire user_live;
	wire cfg_live;
	wire pad_level;
	wire in_enabled;

	// float control only turns the driver off; the input path stays open
	assign cfg_live   = I_CFG_DONE & ~I_POR;                          // [R12] [R13]
	assign cell_rst   = I_RST | I_POR | ~I_CFG_DONE;                  // [R13] [R16]
	assign user_live  = cfg_live & ~I_GLOBAL_FLOAT_CONTROL;           // [R12] [R15]
	assign in_enabled = cfg_live & I_CELL_USED;                       // [R11]

	//----------------------------------------
	// pad sampling and input blocking
	//----------------------------------------
	// pad is asynchronous to every clock here, so it is sampled on I_MCLK

	io_pad_sync u_sync
	(
		.i_clk   (I_MCLK),
		.i_rst   (I_RST),
		.i_pad   (I_PAD),
		.o_level (pad_level)
	);

	wire pad_in;
	assign pad_in = pad_level & in_enabled;                          // [R11]

	//----------------------------------------
	// mode decode
	//----------------------------------------
	// unlisted codes fall back to the direct paths
	wire in_mode_reg;
	wire in_mode_ddr;
	wire out_mode_reg;
	wire out_mode_ddr;
	wire oe_mode_reg;

	assign in_mode_reg  = (I_IN_MODE == `IN_MODE_REG);               // [R1]
	assign in_mode_ddr  = (I_IN_MODE == `IN_MODE_DDR);               // [R2]
	assign out_mode_reg = (I_OUT_MODE == `OUT_MODE_REG);             // [R3]
	assign out_mode_ddr = (I_OUT_MODE == `OUT_MODE_DDR);             // [R4]
	assign oe_mode_reg  = (I_OE_MODE == `OE_MODE_REG);               // [R5]

	//----------------------------------------
	// clock enable distribution
	//----------------------------------------
	// one shared enable; separate nets keep each block's gating visible
	wire in_ce;
	wire out_ce;
	wire oe_ce;

	assign in_ce  = I_CLOCK_ENABLE;                                  // [R8] [R18]
	assign out_ce = I_CLOCK_ENABLE;                                  // [R18]
	assign oe_ce  = I_CLOCK_ENABLE;                                  // [R18]

	//----------------------------------------
	// input register block
	//----------------------------------------
	// registered inputs freeze only by the core holding the clock enable low
	wire in_rise_q;
	wire in_fall_q;

	io_ce_flop
	#(
		.NEG_EDGE (0)
	)
	u_in_rise                                                        // [R1] [R2] [R5] [R18] [R8]
	(
		.i_clk (I_INPUT_CLK),
		.i_rst (cell_rst),
		.i_ce  (in_ce),
		.i_d   (pad_in),
		.o_q   (in_rise_q)
	);

	io_ce_flop
	#(
		.NEG_EDGE (1)
	)
	u_in_fall                                                        // [R2] [R18]
	(
		.i_clk (I_INPUT_CLK),
		.i_rst (cell_rst),
		.i_ce  (in_ce),
		.i_d   (pad_in),
		.o_q   (in_fall_q)
	);

	//----------------------------------------
	// freeze latch on the direct input path
	//----------------------------------------
	// latch modelled as a flop on the system clock to avoid a real latch
	reg  hold_reg;
	wire freeze_on;

	wire freeze_opt_in;

	assign freeze_opt_in = I_FREEZE_EN;                              // [R7]
	assign freeze_on     = freeze_opt_in & I_BANK_FREEZE;            // [R7] [R9]

	always @(posedge I_MCLK or posedge cell_rst)
	begin
		if (cell_rst)
		begin
			hold_reg <= `CELL_FF_RESET;                               // [R16]
		end
		else if (!freeze_on)
		begin
			hold_reg <= pad_in;                                       // [R6]
		end
	end

	wire direct_in;
	assign direct_in = freeze_on ? hold_reg : pad_in;               // [R6]

	always @*
	begin
		O_D_IN_0 = direct_in;
		O_D_IN_1 = 1'h0;
		if (in_mode_ddr)
		begin
			O_D_IN_0 = in_rise_q;                                     // [R2]
			O_D_IN_1 = in_fall_q;                                     // [R2]
		end
		else if (in_mode_reg)
		begin
			O_D_IN_0 = in_rise_q;                                     // [R1]
		end
		else
		begin
			O_D_IN_0 = direct_in;                                     // [R6]
		end
	end

	//----------------------------------------
	// output register block
	//----------------------------------------
	wire out_rise_q;
	wire out_fall_q;
	wire oe_q;

	io_ce_flop
	#(
		.NEG_EDGE (0)
	)
	u_out_rise                                                       // [R3] [R4] [R5] [R18]
	(
		.i_clk (I_OUTPUT_CLK),
		.i_rst (cell_rst),
		.i_ce  (out_ce),
		.i_d   (I_D_OUT_0),
		.o_q   (out_rise_q)
	);

	io_ce_flop
	#(
		.NEG_EDGE (1)
	)
	u_out_fall                                                       // [R4] [R18]
	(
		.i_clk (I_OUTPUT_CLK),
		.i_rst (cell_rst),
		.i_ce  (out_ce),
		.i_d   (I_D_OUT_1),
		.o_q   (out_fall_q)
	);

	//----------------------------------------
	// tri-state register block
	//----------------------------------------
	io_ce_flop
	#(
		.NEG_EDGE (0)
	)
	u_oe                                                             // [R5] [R18]
	(
		.i_clk (I_OUTPUT_CLK),
		.i_rst (cell_rst),
		.i_ce  (oe_ce),
		.i_d   (I_OUTPUT_ENABLE),
		.o_q   (oe_q)
	);

	reg out_sel;

	// ddr mux follows the clock level: rise data while high, fall data while low
	always @*
	begin
		out_sel = I_D_OUT_0;
		if (out_mode_ddr)
		begin
			if (I_OUTPUT_CLK)
				out_sel = out_rise_q;                                 // [R4]
			else
				out_sel = out_fall_q;                                 // [R4]
		end
		else if (out_mode_reg)
		begin
			out_sel = out_rise_q;                                     // [R3]
		end
	end

	wire oe_sel;
	assign oe_sel = oe_mode_reg ? oe_q : I_OUTPUT_ENABLE;            // [R5] [R17]

	//----------------------------------------
	// pad drive and keeper
	//----------------------------------------
	reg pad_oe_c;
	reg pad_pullup_c;
	reg pad_out_c;

	// driver: off until configured, off when unused or floated
	always @*
	begin
		if (!cfg_live)
			pad_oe_c = 1'h0;                                          // [R12] [R13]
		else if (!I_CELL_USED)
			pad_oe_c = 1'h0;                                          // [R11]
		else if (!user_live)
			pad_oe_c = 1'h0;                                          // [R15]
		else
			pad_oe_c = oe_sel;                                        // [R17]
	end

	// keeper: pull-up before configuration, off when unused, else per-pad choice
	always @*
	begin
		if (!cfg_live)
			pad_pullup_c = 1'h1;                                      // [R10]
		else if (!I_CELL_USED)
			pad_pullup_c = 1'h0;                                      // [R11]
		else if (I_KEEPER == `KEEP_PULLUP)
			pad_pullup_c = 1'h1;                                      // [R14]
		else
			pad_pullup_c = 1'h0;                                      // [R14]
	end

	// a floating pad shows 0, never a stale drive value
	always @*
	begin
		if (pad_oe_c)
			pad_out_c = out_sel;                                      // [R17]
		else
			pad_out_c = 1'h0;
	end

	assign O_PAD        = pad_out_c;
	assign O_PAD_OE     = pad_oe_c;
	assign O_PAD_PULLUP = pad_pullup_c;
endmodule

// File: test/io_cell_chk.sv
`timescale 1ns/100ps
`include "io_cell_defines.vh"
module io_cell_chk(
	input logic I_MCLK, I_RST, I_POR, I_CFG_DONE, I_CELL_USED, I_KEEPER,
	input logic I_GLOBAL_FLOAT_CONTROL, I_FREEZE_EN, I_BANK_FREEZE,
	input logic I_OUTPUT_CLK, I_CLOCK_ENABLE, I_D_OUT_0, I_D_OUT_1,
	input logic I_OE_MODE, I_OUTPUT_ENABLE,
	input logic [1:0] I_IN_MODE, I_OUT_MODE,
	input logic O_D_IN_0, O_PAD, O_PAD_OE, O_PAD_PULLUP);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	wire live = I_CFG_DONE & ~I_POR;
	wire on = live & I_CELL_USED & O_PAD_OE;
	wire ddr = on & I_CLOCK_ENABLE & (I_OUT_MODE == `OUT_MODE_DDR);
	wire hold = on & ~I_CLOCK_ENABLE & (I_OUT_MODE == `OUT_MODE_REG);
	wire frz = live & I_CELL_USED & I_FREEZE_EN & I_BANK_FREEZE
		& (I_IN_MODE == `IN_MODE_DIRECT);
	// an edge that fell inside reset is not judged
	sequence s_ddr;
		ddr && $past(ddr) && !$past(I_RST);
	endsequence
	sequence s_frz;
		frz [*2];
	endsequence
	AST_CFG: assert property (!live |-> !O_PAD_OE && O_PAD_PULLUP)
		else $error("pad live");
	AST_FLOAT: assert property (I_GLOBAL_FLOAT_CONTROL |-> !O_PAD_OE)
		else $error("float");
	AST_OE: assert property (live && I_CELL_USED && !I_GLOBAL_FLOAT_CONTROL
		&& (I_OE_MODE == `OE_MODE_DIRECT) |-> O_PAD_OE == I_OUTPUT_ENABLE)
		else $error("output enable");
	AST_OFF: assert property (!O_PAD_OE |-> !O_PAD)
		else $error("pad driven while off");
	AST_UNUSED: assert property (live && !I_CELL_USED |-> !O_PAD_OE && !O_PAD_PULLUP
		&& !O_D_IN_0) else $error("unused");
	AST_KEEP: assert property (live && I_CELL_USED |-> O_PAD_PULLUP == I_KEEPER)
		else $error("keeper");
	AST_FRZ: assert property (s_frz |-> $stable(O_D_IN_0))
		else $error("freeze");
	AST_HOLD: assert property (hold [*2] |-> $stable(O_PAD))
		else $error("ce hold");
	AST_RISE: assert property (s_ddr ##0 ($rose(I_OUTPUT_CLK) && $stable(I_D_OUT_0))
		|-> O_PAD == I_D_OUT_0) else $error("rise");
	AST_FALL: assert property (s_ddr ##0 ($fell(I_OUTPUT_CLK) && $stable(I_D_OUT_1))
		|-> O_PAD == I_D_OUT_1) else $error("fall");
endmodule
bind io_cell io_cell_chk io_cell_chk_inst (.*);

// File: test/io_core_model.sv
`timescale 1ns/100ps
module io_core_model(
	input  wire i_clk,
	input  wire i_run,
	output reg  o_clk = 1'h0,
	output reg  o_d0 = 1'h0,
	output reg  o_d1 = 1'h1
);
	reg [1:0] ph_reg = 2'h0;
	// data moves a cycle away from either clock edge
	always @(negedge i_clk)
		if (i_run)
		begin
			ph_reg <= ph_reg + 2'h1;
			if (!ph_reg[0])
				o_clk <= ~ph_reg[1];
			else if (!ph_reg[1])
				o_d1 <= ~o_d0;
			else
				o_d0 <= ~o_d0;
		end
endmodule

// File: test/io_cell_tb.sv
`timescale 1ns/100ps
`include "io_cell_defines.vh"
module io_cell_tb;
	logic I_MCLK=0, I_RST=1, I_POR=0, I_CFG_DONE=0, I_CELL_USED=1, I_KEEPER=1, I_PAD=1;
	logic I_GLOBAL_FLOAT_CONTROL=0, I_OE_MODE=0, I_FREEZE_EN=0, I_BANK_FREEZE=0;
	logic I_CLOCK_ENABLE=1, I_OUTPUT_ENABLE=1, run=0, p;
	logic [1:0] I_IN_MODE=0, I_OUT_MODE=0;
	wire I_OUTPUT_CLK, I_D_OUT_0, I_D_OUT_1, O_D_IN_0, O_D_IN_1, O_PAD, O_PAD_OE, O_PAD_PULLUP;
	int num_errors=0, checks=0;
	io_core_model io_core_model_inst (.i_clk(I_MCLK), .i_run(run), .o_clk(I_OUTPUT_CLK),
		.o_d0(I_D_OUT_0), .o_d1(I_D_OUT_1));
	io_cell io_cell_inst (.*, .I_INPUT_CLK(I_OUTPUT_CLK));
	initial
		forever #2 I_MCLK = ~I_MCLK;
	initial
	begin
		#20000 num_errors++;
		test_done;
	end
	task chk(string n, logic e, logic s);
		checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, s);
		end
	endtask
	task test_done;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task cyc(int n);
		repeat (n) @(negedge I_MCLK);
	endtask
	task t_cfg;
		chk("pu", 1, O_PAD_PULLUP);
		chk("oe", 0, O_PAD_OE);
		I_CFG_DONE = 1;
		I_GLOBAL_FLOAT_CONTROL = 1;
		cyc(5);
		chk("oe", 0, O_PAD_OE);
		chk("din", 1, O_D_IN_0);
		I_GLOBAL_FLOAT_CONTROL = 0;
		I_CELL_USED = 0;
		cyc(1);
		chk("din", 0, O_D_IN_0);
		I_CELL_USED = 1;
		cyc(5);
		chk("oe", 1, O_PAD_OE);
	endtask
	task t_frz;
		I_FREEZE_EN = 1;
		I_BANK_FREEZE = 1;
		I_PAD = 0;
		cyc(6);
		chk("din", 1, O_D_IN_0);
		I_FREEZE_EN = 0;
		cyc(6);
		chk("din", 0, O_D_IN_0);
		I_FREEZE_EN = 1;
		I_PAD = 1;
		cyc(6);
		chk("din", 0, O_D_IN_0);
		I_BANK_FREEZE = 0;
		cyc(6);
		chk("din", 1, O_D_IN_0);
	endtask
	task t_ddr;
		I_OUT_MODE = `OUT_MODE_DDR;
		I_IN_MODE = `IN_MODE_DDR;
		I_OE_MODE = `OE_MODE_REG;
		run = 1;
		repeat (4)
		begin
			@(posedge I_OUTPUT_CLK);
			@(posedge I_MCLK) #1;
			chk("rise", I_D_OUT_0, O_PAD);
			@(negedge I_OUTPUT_CLK);
			@(posedge I_MCLK) #1;
			chk("fall", I_D_OUT_1, O_PAD);
		end
		chk("din1", 1, O_D_IN_1);
		chk("din0", 1, O_D_IN_0);
	endtask
	task t_reg;
		cyc(1);
		I_OUT_MODE = `OUT_MODE_REG;
		I_IN_MODE = `IN_MODE_REG;
		I_CLOCK_ENABLE = 0;
		I_PAD = 0;
		@(posedge I_MCLK);
		p = O_PAD;
		cyc(16);
		chk("din", 1, O_D_IN_0);
		chk("pad", p, O_PAD);
		I_CLOCK_ENABLE = 1;
		cyc(16);
		chk("din", 0, O_D_IN_0);
		I_POR = 1;
		cyc(1);
		chk("oe", 0, O_PAD_OE);
	endtask
	initial
	begin
		cyc(8);
		I_RST = 0;
		cyc(1);
		t_cfg;
		t_frz;
		t_ddr;
		t_reg;
		test_done;
	end
endmodule
